// file: verilog/transient_pkg.sv
// Constants and types shared by the transient event detector and its helpers.
// Assumes a single 20 MHz system clock and byte-wide registers.
package transient_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_TRANSIENT_CONFIG         = 8'h1d;
  localparam logic [7:0] ADDR_TRANSIENT_SOURCE         = 8'h1e;
  localparam logic [7:0] ADDR_TRANSIENT_THRESHOLD      = 8'h1f;
  localparam logic [7:0] ADDR_TRANSIENT_DEBOUNCE_COUNT = 8'h20;

  // Reset values
  localparam logic [7:0] CONFIG_RESET    = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;

  // Configuration fields; axis enables sit at CFG_X_ENABLE_BIT + axis index
  localparam int CFG_FILTER_BYPASS_BIT = 0;
  localparam int CFG_X_ENABLE_BIT      = 1;
  localparam int CFG_LATCH_BIT         = 4;
  localparam int CFG_USED_BITS         = 5;

  // Source fields; axis i has polarity at 2*i and event at 2*i+1
  localparam int SRC_EVENT_ACTIVE_BIT = 6;
  localparam int NUM_AXES             = 3;

  // Threshold fields
  localparam int THS_MODE_BIT = 7;
  localparam int THS_WIDTH    = 7;
  // 0.063 g per step; 63 steps is the last one at or below 4 g
  localparam logic [6:0] LOW_NOISE_THS_MAX = 7'h3f;

  // Samples are 14-bit two's complement on the 8 g scale (1024 counts per g)
  localparam int SAMPLE_WIDTH = 14;
  // Right shift that turns a sample magnitude into threshold steps of 1/16 g
  localparam int MAG_SHIFT    = 6;

  // Debounce time step: multiples of the 1.25 ms step at 800 Hz
  localparam int STEP_BASE_US        = 1250;
  localparam int STEP_CYCLES_PER_US  = 20;
  localparam logic [7:0] NORMAL_MAX_UNITS  = 8'h10;
  localparam logic [7:0] LOW_POWER_LOW_NOISE_MODE_MAX_UNITS    = 8'h40;
  localparam logic [7:0] HIGH_RESOLUTION_MODE_MAX_UNITS = 8'h02;
  localparam logic [7:0] RATE5_UNITS       = 8'h40;
  localparam logic [7:0] RATE_SLOW_UNITS   = 8'h80;

  // Oversampling modes
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'b00,
    MODE_LOW_POWER_LOW_NOISE_MODE    = 2'b01,
    MODE_HIGH_RESOLUTION_MODE = 2'b10,
    MODE_LP      = 2'b11
  } osr_mode_t;

endpackage : transient_pkg

// file: verilog/axis_threshold_compare.sv
// One axis: selects filtered or unfiltered data and compares its magnitude.
// Assumes samples are already on the 8 g scale, whatever the output range.
`timescale 1ns/1ps
module axis_threshold_compare
  import transient_pkg::*;
#(
  parameter int SAMPLE_W = SAMPLE_WIDTH
) (
  input  wire logic signed [SAMPLE_W-1:0] filt_sample_i,
  input  wire logic signed [SAMPLE_W-1:0] raw_sample_i,
  input  wire logic                       filter_bypass_i,
  input  wire logic [THS_WIDTH-1:0]       threshold_i,
  output logic                            over_o,
  output logic                            negative_o
);

  logic signed [SAMPLE_W-1:0] sel;
  logic        [SAMPLE_W-1:0] mag;
  logic        [SAMPLE_W-MAG_SHIFT-1:0] steps;

  assign sel        = filter_bypass_i ? raw_sample_i : filt_sample_i;
  assign negative_o = sel[SAMPLE_W-1];
  // The most negative code maps onto its own unsigned value, so no overflow
  assign mag        = negative_o ? SAMPLE_W'(-sel) : SAMPLE_W'(sel);
  assign steps      = mag[SAMPLE_W-1:MAG_SHIFT];
  assign over_o     = steps > (SAMPLE_W-MAG_SHIFT)'(threshold_i);

endmodule : axis_threshold_compare

// file: verilog/debounce_step_timer.sv
// Debounce time-step generator: one-cycle pulse per time step.
// Assumes rate and mode inputs are static between reconfigurations.
`timescale 1ns/1ps
module debounce_step_timer
  import transient_pkg::*;
#(
  parameter int CYCLES_PER_US = STEP_CYCLES_PER_US
) (
  input  wire logic      clk_sys_i,
  input  wire logic      rst_i,
  input  wire logic [2:0] output_sample_rate_i,
  input  wire osr_mode_t oversample_mode_i,
  output logic           step_o
);

  localparam int BASE_CYCLES = STEP_BASE_US * CYCLES_PER_US;

  logic [23:0] base_cnt_reg;
  logic [7:0]  unit_cnt_reg;
  logic [7:0]  rate_units;
  logic [7:0]  step_units;
  logic        base_tick;

  // Rate index 0..7 is 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
  always_comb begin
    case (output_sample_rate_i)
      3'd5:    rate_units = RATE5_UNITS;
      3'd6:    rate_units = RATE_SLOW_UNITS;
      3'd7:    rate_units = RATE_SLOW_UNITS;
      default: rate_units = 8'h01 << output_sample_rate_i;
    endcase
    case (oversample_mode_i)
      MODE_NORMAL:  step_units = (rate_units > NORMAL_MAX_UNITS) ? NORMAL_MAX_UNITS : rate_units;
      MODE_LOW_POWER_LOW_NOISE_MODE:    step_units = (rate_units > LOW_POWER_LOW_NOISE_MODE_MAX_UNITS) ? LOW_POWER_LOW_NOISE_MODE_MAX_UNITS : rate_units;
      MODE_HIGH_RESOLUTION_MODE: step_units = (rate_units > HIGH_RESOLUTION_MODE_MAX_UNITS) ? HIGH_RESOLUTION_MODE_MAX_UNITS : rate_units;
      MODE_LP:      step_units = rate_units;
      default:      step_units = rate_units;
    endcase
  end

  assign base_tick = (base_cnt_reg == 24'(BASE_CYCLES - 1));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || base_tick) begin
      base_cnt_reg <= 24'h000000;
    end else begin
      base_cnt_reg <= base_cnt_reg + 24'h000001;
    end
  end

  // A shortened step after a mode change takes effect at the next wrap
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      unit_cnt_reg <= 8'h00;
      step_o       <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (base_tick) begin
        if (unit_cnt_reg + 8'h01 >= step_units) begin
          unit_cnt_reg <= 8'h00;
          step_o       <= 1'b1;
        end else begin
          unit_cnt_reg <= unit_cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule : debounce_step_timer

// file: verilog/transient_accel_event_detector.sv
// Transient acceleration event detector: registers, debounce and source flags.
// Assumes filtered and raw samples are synchronous and held between updates,
// and that register strobes come from the device's serial register port.
//
// Summary of operation
// - Bypass bit 0 picks unfiltered data instead of high-pass filtered data.
// - Config bits 3,2,1 enable Z, Y, X event detection.
// - Latch bit 4 holds flags until source read; clear means no latching.
// - Once event-active sets with latching, existing status bits stay frozen.
// - Reading the source register clears all status and the interrupt request; a step qualifying in the same cycle still sets its flags.
// - While event-active with latching, new axis events may add bits; none clear before read.
// - Event-active at bit 6 is the OR of all three axis event flags.
// - Source holds event/polarity pairs: Z 5/4, Y 3/2, X 1/0; 1 is negative.
// - Axis trips when its unsigned magnitude strictly exceeds the 7-bit threshold.
// - Comparison spans up to 8 g regardless of full-scale range.
// - Low-noise mode caps the effective threshold at 4 g.
// - Threshold bit 7: 0 up/down debounce, 1 up/clear debounce.
// - The 8-bit count sets qualifying steps needed before the flag rises.
// - Time step is one output-rate period, at most 128 base steps, clipped per oversampling mode.
// - A qualified event raises the flag and, if enabled, the interrupt request.
// - A false step decrements to zero, or clears the counter in clear mode.
// - The debounce counter saturates at the programmed count.
`timescale 1ns/1ps
module transient_accel_event_detector
  import transient_pkg::*;
#(
  parameter int CYCLES_PER_US = STEP_CYCLES_PER_US,
  parameter int SAMPLE_W      = SAMPLE_WIDTH
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_rd_i,
  output logic      [7:0]                 reg_rdata_o,
  input  wire logic signed [SAMPLE_W-1:0] filt_x_i,
  input  wire logic signed [SAMPLE_W-1:0] filt_y_i,
  input  wire logic signed [SAMPLE_W-1:0] filt_z_i,
  input  wire logic signed [SAMPLE_W-1:0] raw_x_i,
  input  wire logic signed [SAMPLE_W-1:0] raw_y_i,
  input  wire logic signed [SAMPLE_W-1:0] raw_z_i,
  input  wire logic                       low_power_low_noise_mode_i,
  input  wire logic [2:0]                 output_sample_rate_i,
  input  wire osr_mode_t                  oversample_mode_i,
  input  wire logic                       irq_enable_i,
  output logic                            event_active_o,
  output logic                            irq_o
);

  logic [CFG_USED_BITS-1:0] config_reg;
  logic [7:0]               threshold_reg;
  logic [7:0]               count_reg;
  logic [7:0]               cnt_reg;
  logic [7:0]               cnt_next;
  logic [2*NUM_AXES-1:0]    src_reg;
  logic [2*NUM_AXES-1:0]    src_next;
  logic                     ea_reg;
  logic                     ea_next;
  logic                     irq_reg;

  logic signed [SAMPLE_W-1:0] filt_a [NUM_AXES];
  logic signed [SAMPLE_W-1:0] raw_a  [NUM_AXES];
  logic [NUM_AXES-1:0]        over;
  logic [NUM_AXES-1:0]        negative;
  logic [NUM_AXES-1:0]        axis_en;
  logic [THS_WIDTH-1:0]       ths_eff;
  logic                       step;
  logic                       any_cond;
  logic                       qual;
  logic                       latch_en;
  logic                       clear_mode;
  logic                       src_rd;

  assign filt_a = '{filt_x_i, filt_y_i, filt_z_i};
  assign raw_a  = '{raw_x_i, raw_y_i, raw_z_i};

  assign axis_en    = config_reg[CFG_X_ENABLE_BIT +: NUM_AXES];
  assign latch_en   = config_reg[CFG_LATCH_BIT];
  assign clear_mode = threshold_reg[THS_MODE_BIT];
  assign src_rd     = reg_rd_i && (reg_addr_i == ADDR_TRANSIENT_SOURCE);

  // Low-noise operation halves the reachable range, so clip the threshold
  assign ths_eff = (low_power_low_noise_mode_i && threshold_reg[THS_WIDTH-1:0] > LOW_NOISE_THS_MAX)
                   ? LOW_NOISE_THS_MAX : threshold_reg[THS_WIDTH-1:0];

  debounce_step_timer #(
    .CYCLES_PER_US (CYCLES_PER_US)
  ) u_step_timer (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .output_sample_rate_i (output_sample_rate_i),
    .oversample_mode_i    (oversample_mode_i),
    .step_o               (step)
  );

  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    axis_threshold_compare #(
      .SAMPLE_W (SAMPLE_W)
    ) u_cmp (
      .filt_sample_i   (filt_a[i]),
      .raw_sample_i    (raw_a[i]),
      .filter_bypass_i (config_reg[CFG_FILTER_BYPASS_BIT]),
      .threshold_i     (ths_eff),
      .over_o          (over[i]),
      .negative_o      (negative[i])
    );
  end

  assign any_cond = |(over & axis_en);

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      config_reg    <= CONFIG_RESET[CFG_USED_BITS-1:0];
      threshold_reg <= THRESHOLD_RESET;
      count_reg     <= COUNT_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_TRANSIENT_CONFIG:         config_reg    <= reg_wdata_i[CFG_USED_BITS-1:0];
        ADDR_TRANSIENT_THRESHOLD:      threshold_reg <= reg_wdata_i;
        ADDR_TRANSIENT_DEBOUNCE_COUNT: count_reg     <= reg_wdata_i;
        default:                       ;
      endcase
    end
  end

  // Register reads; source is the only register with a side effect
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_TRANSIENT_CONFIG:         reg_rdata_o <= {{(8-CFG_USED_BITS){1'b0}}, config_reg};
        ADDR_TRANSIENT_SOURCE:         reg_rdata_o <= {1'b0, ea_reg, src_reg};
        ADDR_TRANSIENT_THRESHOLD:      reg_rdata_o <= threshold_reg;
        ADDR_TRANSIENT_DEBOUNCE_COUNT: reg_rdata_o <= count_reg;
        default:                       reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Debounce counter, advanced once per time step
  always_comb begin
    cnt_next = cnt_reg;
    if (any_cond) begin
      cnt_next = (cnt_reg < count_reg) ? cnt_reg + 8'h01 : count_reg;
    end else if (clear_mode) begin
      cnt_next = 8'h00;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  assign qual = step && any_cond && (cnt_next >= count_reg);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
    end else if (step) begin
      cnt_reg <= cnt_next;
    end
  end

  // Source flags. A step that qualifies in the same cycle as a source read
  // wins over the clear, so the new event is not lost.
  always_comb begin
    src_next = src_rd ? '0 : src_reg;
    if (step) begin
      for (int i = 0; i < NUM_AXES; i++) begin
        if (latch_en) begin
          // Bits already set stay frozen; idle axes may still join
          if (qual && axis_en[i] && over[i] && !src_next[2*i+1]) begin
            src_next[2*i+1] = 1'b1;
            src_next[2*i]   = negative[i];
          end
        end else begin
          src_next[2*i+1] = qual && axis_en[i] && over[i];
          src_next[2*i]   = qual && axis_en[i] && over[i] && negative[i];
        end
      end
    end
    ea_next = 1'b0;
    for (int i = 0; i < NUM_AXES; i++) begin
      ea_next = ea_next | src_next[2*i+1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_reg <= '0;
      ea_reg  <= 1'b0;
    end else begin
      src_reg <= src_next;
      ea_reg  <= ea_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ea_next && irq_enable_i;
    end
  end

  assign event_active_o = ea_reg;
  assign irq_o          = irq_reg;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic any_ev;
  assign any_ev = src_reg[1] | src_reg[3] | src_reg[5];

  chk_ea_matches_flags: assert property (ea_reg == any_ev)
    else $error("event active disagrees with axis flags");

  chk_read_clears_src: assert property (src_rd && !step |=> (src_reg == '0) && !ea_reg)
    else $error("source read did not clear status");

  chk_irq_withdrawn: assert property (src_rd && !step |=> !irq_o)
    else $error("interrupt request not withdrawn after read");

  chk_irq_follows_ea: assert property (irq_o == (ea_reg && $past(irq_enable_i)))
    else $error("interrupt request does not follow event active");

  chk_cnt_saturates: assert property (step && any_cond && !reg_wr_i |=> cnt_reg <= count_reg)
    else $error("debounce counter passed the count value");

  chk_clear_mode_zero: assert property (step && !any_cond && clear_mode |=> cnt_reg == 8'h00)
    else $error("clear mode did not reset the counter");

  chk_dec_mode_step: assert property (step && !any_cond && !clear_mode && cnt_reg != 8'h00
                                      |=> cnt_reg == $past(cnt_reg) - 8'h01)
    else $error("decrement mode did not lower the counter by one");

  chk_latch_holds_bits: assert property (latch_en && !src_rd
                                         |=> ($past(src_reg) & ~src_reg & 6'h2a) == 6'h00)
    else $error("latched event bit cleared without a read");

  chk_latch_freeze_pol: assert property (latch_en && !src_rd && src_reg[1]
                                         |=> src_reg[0] == $past(src_reg[0]))
    else $error("frozen polarity changed while latched");

  chk_nolatch_follows: assert property (step && !latch_en && !qual |=> src_reg == '0)
    else $error("unlatched flags did not follow detection");

  chk_disabled_axis: assert property (step && !latch_en && !axis_en[0] |=> !src_reg[1])
    else $error("disabled axis raised its flag");

  // A polarity bit never stands without its axis event bit
  chk_pol_needs_event: assert property (((src_reg & 6'h15) & ~(src_reg >> 1)) == 6'h00)
    else $error("polarity bit set without its event bit");

  chk_low_noise_cap: assert property (low_power_low_noise_mode_i |-> ths_eff <= LOW_NOISE_THS_MAX)
    else $error("low-noise threshold above the 4 g cap");

  chk_cnt_only_on_step: assert property (!step |=> $stable(cnt_reg))
    else $error("debounce counter moved between time steps");

  cov_latched_event: cover property (latch_en && qual ##1 ea_reg);
  cov_read_clear:    cover property (ea_reg && src_rd ##1 !ea_reg);
  cov_decrement:     cover property (step && !any_cond && !clear_mode && cnt_reg != 8'h00);
  cov_add_axis:      cover property (ea_reg && latch_en ##1 ($countones(src_reg & 6'h2a) > 1));

endmodule : transient_accel_event_detector

// file: dv/host_reg_model.sv
// Host processor model: byte-wide register reads and writes on the strobe port.
// Assumes the detector answers a read on the edge that takes it.
`timescale 1ns/1ps
module host_reg_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // Idle address and data are inverted so a stale value never looks live
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o  = addr;
    reg_wdata_o = data;
    reg_wr_o    = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~addr;
    reg_wdata_o = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = addr;
    reg_rd_o   = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~addr;
    data       = reg_rdata_i;
  endtask : rd
endmodule : host_reg_model

// file: dv/transient_accel_event_detector_tb_top.sv
// Self-checking bench for the transient event detector.
// Assumes a 1250-cycle debounce step (800 Hz, normal mode, one cycle per us).
`timescale 1ns/1ps
module transient_accel_event_detector_tb_top;
  import transient_pkg::*;
  localparam int STEP = 1250;
  logic               clk_sys_i;
  logic               rst_i;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  logic               reg_wr;
  logic               reg_rd;
  logic signed [13:0] filt_x, filt_y, filt_z, raw_x, raw_y, raw_z;
  logic               low_power_low_noise_mode;
  logic [2:0]         osr_rate;
  osr_mode_t          osr_mode;
  logic               irq_en;
  logic               ea;
  logic               irq;
  logic [7:0]         v;
  int                 n_fail, checked, base;
  int                 cyc = 0;

  transient_accel_event_detector #(.CYCLES_PER_US(1), .SAMPLE_W(14)) transient_accel_event_detector_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .filt_x_i(filt_x), .filt_y_i(filt_y), .filt_z_i(filt_z),
    .raw_x_i(raw_x), .raw_y_i(raw_y), .raw_z_i(raw_z),
    .low_power_low_noise_mode_i(low_power_low_noise_mode), .output_sample_rate_i(osr_rate), .oversample_mode_i(osr_mode),
    .irq_enable_i(irq_en), .event_active_o(ea), .irq_o(irq));

  host_reg_model host_reg_model_inst (
    .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // About 40 steps of 1250 cycles are used; the ceiling leaves wide headroom
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    host_reg_model_inst.rd(addr, v);
    check(v, exp);
  endtask : rdc

  // Lands two cycles after a step edge so flag updates have settled
  task automatic wait_steps(input int n);
    base = base + n * STEP;
    while (cyc < base + 2) @(posedge clk_sys_i);
    #1;
  endtask : wait_steps

  task automatic reset_regs();
    rdc(ADDR_TRANSIENT_CONFIG, 8'h00);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h00);
    rdc(ADDR_TRANSIENT_THRESHOLD, 8'h00);
    rdc(ADDR_TRANSIENT_DEBOUNCE_COUNT, 8'h00);
    rdc(8'h21, 8'h00);
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'hff);
    rdc(ADDR_TRANSIENT_CONFIG, 8'h1f);
    host_reg_model_inst.wr(ADDR_TRANSIENT_SOURCE, 8'h55);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h00);
    host_reg_model_inst.wr(8'h21, 8'haa);
    rdc(8'h21, 8'h00);
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, 8'ha5);
    rdc(ADDR_TRANSIENT_THRESHOLD, 8'ha5);
    host_reg_model_inst.wr(ADDR_TRANSIENT_DEBOUNCE_COUNT, 8'h5a);
    rdc(ADDR_TRANSIENT_DEBOUNCE_COUNT, 8'h5a);
  endtask : reset_regs

  // Finds the step phase from the first unlatched X event
  task automatic unlatched_x();
    int i;
    i = 0;
    irq_en = 1'b1;
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, 8'h10);
    host_reg_model_inst.wr(ADDR_TRANSIENT_DEBOUNCE_COUNT, 8'h00);
    raw_x = 14'sd1088;
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h03);
    while (ea !== 1'b1 && i < 1400) begin
      @(posedge clk_sys_i);
      i++;
    end
    base = cyc - 1;
    #1;
    check({7'h00, irq}, 8'h01);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h42);
    check({6'h00, ea, irq}, 8'h00);
    irq_en = 1'b0;
    wait_steps(1);
    check({6'h00, ea, irq}, 8'h02);
    raw_x = 14'sd1087;
    wait_steps(1);
    check({7'h00, ea}, 8'h00);
  endtask : unlatched_x

  task automatic source_select();
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h0e);
    raw_x = 14'sd2000;
    wait_steps(1);
    check({7'h00, ea}, 8'h00);
    filt_z = -14'sd1088;
    wait_steps(1);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h70);
    filt_z = 14'sd0;
    raw_x = 14'sd0;
    raw_y = -14'sd3000;
    raw_z = 14'sd1088;
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h09);
    wait_steps(1);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h60);
    raw_y = 14'sd0;
    raw_z = 14'sd0;
  endtask : source_select

  task automatic range_limits();
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h03);
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, 8'h7e);
    raw_x = 14'sd8128;
    wait_steps(1);
    check({7'h00, ea}, 8'h01);
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, 8'h7f);
    raw_x = 14'sd4096;
    low_power_low_noise_mode = 1'b1;
    wait_steps(1);
    check({7'h00, ea}, 8'h01);
    low_power_low_noise_mode = 1'b0;
    wait_steps(1);
    check({7'h00, ea}, 8'h00);
  endtask : range_limits

  task automatic latched_flags();
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, 8'h10);
    raw_x = 14'sd1088;
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h1f);
    wait_steps(1);
    raw_x = -14'sd1088;
    raw_y = -14'sd1088;
    wait_steps(1);
    raw_x = 14'sd0;
    raw_y = 14'sd0;
    wait_steps(1);
    check({7'h00, ea}, 8'h01);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h4e);
    rdc(ADDR_TRANSIENT_SOURCE, 8'h00);
  endtask : latched_flags

  task automatic debounce_run(input logic [7:0] ths, input logic [15:0] pat, input logic [15:0] exp,
                              input int n);
    int i;
    host_reg_model_inst.wr(ADDR_TRANSIENT_THRESHOLD, ths);
    raw_x = 14'sd0;
    wait_steps(3);
    for (i = 0; i < n; i++) begin
      raw_x = pat[i] ? 14'sd1088 : 14'sd0;
      wait_steps(1);
      check({7'h00, ea}, {7'h00, exp[i]});
    end
  endtask : debounce_run

  // 100 Hz in high-resolution mode clips to two base steps; the first step after
  // the rate change may come early, so only a later gap is timed
  task automatic step_period();
    int c1;
    int c2;
    osr_rate = 3'h3;
    osr_mode = MODE_HIGH_RESOLUTION_MODE;
    raw_x = 14'sd1088;
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h1f);
    repeat (2) begin
      while (ea !== 1'b1) @(posedge clk_sys_i);
      host_reg_model_inst.rd(ADDR_TRANSIENT_SOURCE, v);
    end
    while (ea !== 1'b1) @(posedge clk_sys_i);
    c1 = cyc;
    host_reg_model_inst.rd(ADDR_TRANSIENT_SOURCE, v);
    while (ea !== 1'b1) @(posedge clk_sys_i);
    c2 = cyc;
    checked++;
    if (c2 - c1 != 2 * STEP) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, c2 - c1, 2 * STEP);
    end
  endtask : step_period

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rst_i = 1'b1;
    low_power_low_noise_mode = 1'b0;
    osr_rate = 3'h0;
    osr_mode = MODE_NORMAL;
    irq_en = 1'b0;
    filt_x = 14'sd0;
    filt_y = 14'sd0;
    filt_z = 14'sd0;
    raw_x = 14'sd0;
    raw_y = 14'sd0;
    raw_z = 14'sd0;
    n_fail = 0;
    checked = 0;
    base = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    reset_regs();
    unlatched_x();
    source_select();
    range_limits();
    latched_flags();
    host_reg_model_inst.wr(ADDR_TRANSIENT_CONFIG, 8'h03);
    host_reg_model_inst.wr(ADDR_TRANSIENT_DEBOUNCE_COUNT, 8'h03);
    // Up/down: 1,2,1,2,3,3,3 saturated, drop to 2, back to 3
    debounce_run(8'h10, 16'h017b, 16'h0170, 9);
    // Up/clear: 1,2,0,1,2,3
    debounce_run(8'h90, 16'h003b, 16'h0020, 6);
    step_period();
    end_of_test();
  end
endmodule : transient_accel_event_detector_tb_top
